// >>> logic/cet_pkg.sv
// constants and types for the camera exposure trigger block
package cet_pkg;
  localparam logic [7:0] CET_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CET_OFF_EXPOSURE = 8'h04;
  localparam logic [7:0] CET_OFF_READOUT  = 8'h08;
  localparam logic [7:0] CET_OFF_PERIOD   = 8'h0C;
  localparam logic [7:0] CET_OFF_COMMAND  = 8'h10;
  localparam logic [7:0] CET_OFF_STATUS   = 8'h14;
  localparam logic [7:0] CET_OFF_COUNT    = 8'h18;
  // control fields
  localparam int CET_CTRL_MODE_LSB = 0;
  localparam int CET_CTRL_MODE_W   = 3;
  localparam int CET_CTRL_SEC_SYNC = 3;
  localparam int CET_CTRL_COOL_EN  = 4;
  localparam int CET_CTRL_ENABLE   = 5;
  localparam int CET_CTRL_W        = 6;
  localparam logic [CET_CTRL_W-1:0] CET_CTRL_RESET = 6'h00;
  localparam logic [31:0] CET_EXPOSURE_RESET = 32'h0000_03E8;
  localparam logic [31:0] CET_READOUT_RESET  = 32'h0000_07D0;
  localparam logic [31:0] CET_PERIOD_RESET   = 32'h0000_2710;
  // exposure lamp held on at least this long so a short integration is visible
  localparam int CET_CLK_MHZ       = 100;
  localparam int CET_LAMP_MIN_US   = 10;
  localparam int CET_LAMP_MIN_CYC  = CET_LAMP_MIN_US * CET_CLK_MHZ;
  localparam int CET_LAMP_W        = 16;
  typedef enum logic [2:0] {
    CET_MODE_CONTINUAL  = 3'h0,
    CET_MODE_EDGE_RISE  = 3'h1,
    CET_MODE_EDGE_FALL  = 3'h2,
    CET_MODE_PULSE_HIGH = 3'h3,
    CET_MODE_PULSE_LOW  = 3'h4,
    CET_MODE_SOFTWARE   = 3'h5
  } cet_mode_t;
endpackage

// >>> logic/cet_apb_regs.sv
// apb slave holding the exposure trigger control registers
`timescale 1ns/1ps
module cet_apb_regs
  import cet_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            status_in,
  input  wire logic [31:0]           count_in,
  output logic      [CET_CTRL_W-1:0] ctrl_reg,
  output logic      [31:0]           exposure_reg,
  output logic      [31:0]           readout_reg,
  output logic      [31:0]           period_reg,
  output logic                       sw_trig_reg
);
  logic [CET_CTRL_W-1:0] ctrl_next;
  logic [31:0]           exposure_next;
  logic [31:0]           readout_next;
  logic [31:0]           period_next;
  logic                  sw_trig_next;
  logic [31:0]           prdata_next;
  logic                  pslverr_next;
  logic                  access;

  assign access = psel && penable;
  assign pready = 1'b1;

  always_comb begin
    ctrl_next     = ctrl_reg;
    exposure_next = exposure_reg;
    readout_next  = readout_reg;
    period_next   = period_reg;
    sw_trig_next  = 1'b0;
    prdata_next   = 32'h0000_0000;
    pslverr_next  = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        CET_OFF_CTRL:     prdata_next = {26'h000_0000, ctrl_reg};
        CET_OFF_EXPOSURE: prdata_next = exposure_reg;
        CET_OFF_READOUT:  prdata_next = readout_reg;
        CET_OFF_PERIOD:   prdata_next = period_reg;
        CET_OFF_COMMAND:  prdata_next = 32'h0000_0000;
        CET_OFF_STATUS:   prdata_next = {24'h00_0000, status_in};
        CET_OFF_COUNT:    prdata_next = count_in;
        default:          pslverr_next = 1'b1;
      endcase
    end
    if (access && pwrite) begin
      unique case (paddr)
        CET_OFF_CTRL:     ctrl_next = pwdata[CET_CTRL_W-1:0];
        CET_OFF_EXPOSURE: exposure_next = pwdata;
        CET_OFF_READOUT:  readout_next = pwdata;
        CET_OFF_PERIOD:   period_next = pwdata;
        CET_OFF_COMMAND:  sw_trig_next = pwdata[0];
        default:          ;
      endcase
    end
    if (access) begin
      prdata_next  = prdata;
      pslverr_next = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= CET_CTRL_RESET;
      exposure_reg <= CET_EXPOSURE_RESET;
      readout_reg  <= CET_READOUT_RESET;
      period_reg   <= CET_PERIOD_RESET;
      sw_trig_reg  <= 1'b0;
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      exposure_reg <= exposure_next;
      readout_reg  <= readout_next;
      period_reg   <= period_next;
      sw_trig_reg  <= sw_trig_next;
      prdata       <= prdata_next;
      pslverr      <= pslverr_next;
    end
  end
endmodule

// >>> logic/cet_down_counter.sv
// loadable down counter with a busy flag, high while the count is not zero
`timescale 1ns/1ps
module cet_down_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  busy
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);
endmodule

// >>> logic/cet_exposure_trigger.sv
// exposure trigger, sync outputs and indicator lamps of the camera
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
// How it works
// - in edge modes a rising or falling edge of the trigger starts a timed exposure.
// - in edge modes a new exposure may start while the previous frame is reading out.
// - in pulse-high mode integration lasts exactly as long as the trigger is high.
// - in pulse-low mode integration lasts exactly as long as the trigger is low.
// - in software mode a host command starts an internally timed exposure.
// - the power lamp is lit while the block is powered and switched on.
// - the exposure lamp flashes for each integration interval.
// - the cooling lamp lights only on cooled variants with cooling enabled.
// - the external trigger pin is active low and is inverted on entry for the edge modes; pulse modes read the raw pin level.
// - the readout sync output is high for the whole readout interval.
// - the secondary sync shows exposure or trigger mask as the host selects.
module cet_exposure_trigger
  import cet_pkg::*;
#(
  parameter bit COOLED = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_switch_on,
  input  wire logic        trigger_n,
  output logic             integrate_reg,
  output logic             readout_reg,
  output logic             sync_readout_reg,
  output logic             secondary_sync_out_reg,
  output logic             lamp_power_reg,
  output logic             lamp_exposure_reg,
  output logic             lamp_cooling_reg
);
  typedef enum logic [1:0] {
    CET_ST_IDLE,
    CET_ST_EXPOSE,
    CET_ST_READOUT
  } cet_state_t;

  logic [CET_CTRL_W-1:0] ctrl_reg;
  logic [31:0]           exposure_reg;
  logic [31:0]           readout_len_reg;
  logic [31:0]           period_reg;
  logic                  sw_trig_reg;
  cet_mode_t             mode;
  logic                  enable;

  cet_state_t            state_reg;
  cet_state_t            state_next;
  logic                  trig_reg;
  logic                  trig_next;
  logic                  trig_prev_reg;
  logic                  exp_load;
  logic                  exp_busy;
  logic                  rd_load;
  logic                  rd_busy;
  logic                  per_load;
  logic                  per_busy;
  logic                  reading_reg;
  logic                  reading_next;
  logic                  start;
  logic                  pulse_mode;
  logic                  pulse_level;
  logic                  can_accept;
  logic                  exp_end;
  logic [31:0]           count_reg;
  logic [31:0]           count_next;
  logic [CET_LAMP_W-1:0] lamp_cnt_reg;
  logic [CET_LAMP_W-1:0] lamp_cnt_next;
  logic [7:0]            status;
  logic                  edge_mode;
  logic                  accept_next;
  logic                  mask_next;
  logic                  integrate_next;
  logic                  readout_next;
  logic                  sync_readout_next;
  logic                  secondary_sync_out_next;
  logic                  lamp_power_next;
  logic                  lamp_exposure_next;
  logic                  lamp_cooling_next;

  assign mode   = cet_mode_t'(ctrl_reg[CET_CTRL_MODE_LSB +: CET_CTRL_MODE_W]);
  assign enable = ctrl_reg[CET_CTRL_ENABLE];
  assign trig_next = ~trigger_n;
  assign pulse_mode  = (mode == CET_MODE_PULSE_HIGH) || (mode == CET_MODE_PULSE_LOW);
  assign edge_mode   = (mode == CET_MODE_EDGE_RISE) || (mode == CET_MODE_EDGE_FALL);
  // raw pin level tells the pulse polarity
  assign pulse_level = (mode == CET_MODE_PULSE_HIGH) ? trigger_n : ~trigger_n;

  assign status = {3'h0, reading_reg, state_reg == CET_ST_EXPOSE, can_accept,
                   lamp_cooling_reg, lamp_power_reg};

  cet_apb_regs u_regs (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .status_in    (status),
    .count_in     (count_reg),
    .ctrl_reg     (ctrl_reg),
    .exposure_reg (exposure_reg),
    .readout_reg  (readout_len_reg),
    .period_reg   (period_reg),
    .sw_trig_reg  (sw_trig_reg)
  );

  cet_down_counter #(.WIDTH(32)) u_exp_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (exp_load),
    .load_value (exposure_reg),
    .busy       (exp_busy)
  );

  cet_down_counter #(.WIDTH(32)) u_rd_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (rd_load),
    .load_value (readout_len_reg),
    .busy       (rd_busy)
  );

  cet_down_counter #(.WIDTH(32)) u_per_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (per_load),
    .load_value (period_reg),
    .busy       (per_busy)
  );

  // edge modes may expose during readout; others wait for the sensor to be idle
  always_comb begin
    can_accept = enable && (state_reg == CET_ST_IDLE);
    if (mode == CET_MODE_EDGE_RISE || mode == CET_MODE_EDGE_FALL) begin
      can_accept = enable && (state_reg != CET_ST_EXPOSE);
    end
  end

  always_comb begin
    start = 1'b0;
    unique case (mode)
      CET_MODE_CONTINUAL:  start = !per_busy;
      CET_MODE_EDGE_RISE:  start = trig_reg && !trig_prev_reg;
      CET_MODE_EDGE_FALL:  start = !trig_reg && trig_prev_reg;
      CET_MODE_PULSE_HIGH: start = pulse_level;
      CET_MODE_PULSE_LOW:  start = pulse_level;
      CET_MODE_SOFTWARE:   start = sw_trig_reg;
      default:             start = 1'b0;
    endcase
    start = start && can_accept;
  end

  assign exp_end = pulse_mode ? !pulse_level : !exp_busy;

  always_comb begin
    state_next   = state_reg;
    exp_load     = 1'b0;
    rd_load      = 1'b0;
    per_load     = 1'b0;
    reading_next = reading_reg && rd_busy;
    count_next   = count_reg;
    if (start) begin
      state_next = CET_ST_EXPOSE;
      exp_load   = 1'b1;
      per_load   = (mode == CET_MODE_CONTINUAL);
      count_next = count_reg + 32'h0000_0001;
    end else if (state_reg == CET_ST_EXPOSE && exp_end) begin
      state_next   = CET_ST_READOUT;
      rd_load      = 1'b1;
      reading_next = 1'b1;
    end else if (state_reg == CET_ST_READOUT && !rd_busy) begin
      state_next = CET_ST_IDLE;
    end
    if (state_reg == CET_ST_EXPOSE && !enable) begin
      state_next = CET_ST_IDLE;
    end
  end

  // exposure lamp stretched so a short exposure still shows
  always_comb begin
    lamp_cnt_next = (lamp_cnt_reg != '0) ? lamp_cnt_reg - 1'b1 : lamp_cnt_reg;
    if (state_next == CET_ST_EXPOSE) begin
      lamp_cnt_next = CET_LAMP_W'(CET_LAMP_MIN_CYC);
    end
  end

  // acceptance as it will stand after this edge, shown as the trigger mask
  always_comb begin
    accept_next = enable && (state_next == CET_ST_IDLE);
    if (edge_mode) begin
      accept_next = enable && (state_next != CET_ST_EXPOSE);
    end
    mask_next = !accept_next;
  end

  // next values of everything on a pin
  always_comb begin
    integrate_next     = (state_next == CET_ST_EXPOSE);
    readout_next       = reading_next;
    sync_readout_next  = reading_next;
    if (ctrl_reg[CET_CTRL_SEC_SYNC]) begin
      secondary_sync_out_next = mask_next;
    end else begin
      secondary_sync_out_next = integrate_next;
    end
    lamp_power_next    = power_switch_on;
    lamp_exposure_next = integrate_next || (lamp_cnt_next != '0);
    lamp_cooling_next  = COOLED && ctrl_reg[CET_CTRL_COOL_EN];
  end

  // trigger pin sampling and its edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_reg      <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_reg      <= trig_next;
      trig_prev_reg <= trig_reg;
    end
  end

  // sequencing state and exposure count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= CET_ST_IDLE;
      reading_reg <= 1'b0;
      count_reg   <= 32'h0000_0000;
    end else begin
      state_reg   <= state_next;
      reading_reg <= reading_next;
      count_reg   <= count_next;
    end
  end

  // exposure lamp stretch counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_cnt_reg <= '0;
    end else begin
      lamp_cnt_reg <= lamp_cnt_next;
    end
  end

  // pin outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integrate_reg          <= 1'b0;
      readout_reg            <= 1'b0;
      sync_readout_reg       <= 1'b0;
      secondary_sync_out_reg <= 1'b0;
      lamp_power_reg         <= 1'b0;
      lamp_exposure_reg      <= 1'b0;
      lamp_cooling_reg       <= 1'b0;
    end else begin
      integrate_reg          <= integrate_next;
      readout_reg            <= readout_next;
      sync_readout_reg       <= sync_readout_next;
      secondary_sync_out_reg <= secondary_sync_out_next;
      lamp_power_reg         <= lamp_power_next;
      lamp_exposure_reg      <= lamp_exposure_next;
      lamp_cooling_reg       <= lamp_cooling_next;
    end
  end
endmodule

// >>> verif/cet_exposure_trigger_props.sv
// assertion checker for the exposure trigger block
`timescale 1ns/1ps
module cet_exposure_trigger_props
  import cet_pkg::*;
#(
  parameter bit COOLED = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_switch_on,
  input wire logic        trigger_n,
  input wire logic        integrate_reg,
  input wire logic        readout_reg,
  input wire logic        sync_readout_reg,
  input wire logic        secondary_sync_out_reg,
  input wire logic        lamp_power_reg,
  input wire logic        lamp_exposure_reg,
  input wire logic        lamp_cooling_reg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [CET_CTRL_W-1:0] ctl_reg;
  logic [CET_CTRL_W-1:0] ctl_next;
  logic [15:0]           lit_reg;
  logic [15:0]           lit_next;
  logic                  wr_ctl;
  logic                  en;
  logic [2:0]            md;
  assign wr_ctl = psel && penable && pwrite && paddr == CET_OFF_CTRL;
  assign en     = ctl_reg[CET_CTRL_ENABLE] && !wr_ctl;
  assign md     = ctl_reg[2:0];
  // shadow of control, cycles the exposure lamp has been lit
  always_comb begin
    ctl_next = wr_ctl ? pwdata[CET_CTRL_W-1:0] : ctl_reg;
    lit_next = lamp_exposure_reg ? lit_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= CET_CTRL_RESET;
      lit_reg <= 16'h0;
    end else begin
      ctl_reg <= ctl_next;
      lit_reg <= lit_next;
    end
  end
  sequence s_rise_req;
    $fell(trigger_n) && en && md == CET_MODE_EDGE_RISE && !integrate_reg ##1 en && !integrate_reg;
  endsequence
  sequence s_cool_held;
    $stable(ctl_reg[CET_CTRL_COOL_EN]) [*2];
  endsequence
  sequence s_expo_held;
    integrate_reg [*2];
  endsequence
  property p_lamp_pwr; 1'b1 |=> lamp_power_reg == $past(power_switch_on); endproperty
  property p_sync_ro;
    $fell(integrate_reg) && $past(ctl_reg[CET_CTRL_ENABLE]) |-> sync_readout_reg && readout_reg;
  endproperty
  property p_exp_lamp; integrate_reg |-> lamp_exposure_reg; endproperty
  property p_lamp_min; $fell(lamp_exposure_reg) |-> lit_reg >= CET_LAMP_MIN_CYC - 1; endproperty
  property p_cool;
    s_cool_held |-> lamp_cooling_reg == (COOLED && ctl_reg[CET_CTRL_COOL_EN]);
  endproperty
  property p_pulse_hi;
    en && md == CET_MODE_PULSE_HIGH && integrate_reg |=> integrate_reg == $past(trigger_n);
  endproperty
  property p_pulse_lo;
    en && md == CET_MODE_PULSE_LOW && integrate_reg |=> integrate_reg == !$past(trigger_n);
  endproperty
  property p_edge; s_rise_req |=> integrate_reg; endproperty
  property p_secondary_sync_out; s_expo_held |-> secondary_sync_out_reg; endproperty
  property p_slverr; psel && penable && paddr > CET_OFF_COUNT |-> pslverr && prdata == 32'h0;
  endproperty
  a_lamp_pwr: assert property (p_lamp_pwr)
    else $error("power lamp does not follow switch");
  a_sync_ro: assert property (p_sync_ro)
    else $error("readout sync not raised at exposure end");
  a_exp_lamp: assert property (p_exp_lamp)
    else $error("exposure lamp dark while integrating");
  a_lamp_min: assert property (p_lamp_min)
    else $error("exposure lamp flash too short");
  a_cool: assert property (p_cool)
    else $error("cooling lamp wrong");
  a_pulse_hi: assert property (p_pulse_hi)
    else $error("high pulse integration wrong");
  a_pulse_lo: assert property (p_pulse_lo)
    else $error("low pulse integration wrong");
  a_edge: assert property (p_edge)
    else $error("edge did not start exposure");
  a_secondary_sync_out: assert property (p_secondary_sync_out)
    else $error("secondary sync low during exposure");
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");
endmodule

// >>> verif/cet_trig_src.sv
// trigger source model driving the isolated trigger pin
`timescale 1ns/1ps
module cet_trig_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [15:0] width,
  input  wire logic        act,
  output logic             trigger_n
);
  logic [15:0] left_reg;
  logic [15:0] left_next;
  logic        pin_next;
  always_comb begin
    left_next = fire ? width : (left_reg > 16'h0 ? left_reg - 16'h1 : 16'h0);
    pin_next  = (fire || left_reg > 16'h1) ? act : !act;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg  <= 16'h0;
      trigger_n <= 1'b1;
    end else begin
      left_reg  <= left_next;
      trigger_n <= pin_next;
    end
  end
endmodule

// >>> verif/testbench.sv
// self-checking testbench for the exposure trigger block
`timescale 1ns/1ps
module testbench;
  import cet_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        power_switch_on = 1'b1;
  logic        fire = 1'b0;
  logic        act = 1'b0;
  logic [15:0] width = 16'h0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, err, trigger_n, integrate_reg, readout_reg, sync_readout_reg;
  logic        secondary_sync_out_reg, lamp_power_reg, lamp_exposure_reg, lamp_cooling_reg;
  int          failures = 0, n_checks = 0, irun = 0, ilen = 0, rrun = 0, rlen = 0, e, r, w;
  cet_exposure_trigger #(.COOLED(1'b1)) u_cet_exposure_trigger (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .power_switch_on        (power_switch_on),
    .trigger_n              (trigger_n),
    .integrate_reg          (integrate_reg),
    .readout_reg            (readout_reg),
    .sync_readout_reg       (sync_readout_reg),
    .secondary_sync_out_reg (secondary_sync_out_reg),
    .lamp_power_reg         (lamp_power_reg),
    .lamp_exposure_reg      (lamp_exposure_reg),
    .lamp_cooling_reg       (lamp_cooling_reg)
  );
  cet_trig_src u_cet_trig_src (.pclk, .presetn, .fire, .width, .act, .trigger_n);
  always #5 pclk = ~pclk;
  // run lengths of integration and readout sync
  always @(posedge pclk) begin
    irun <= integrate_reg ? irun + 1 : 0;
    rrun <= sync_readout_reg ? rrun + 1 : 0;
    if (!integrate_reg && irun != 0) ilen <= irun;
    if (!sync_readout_reg && rrun != 0) rlen <= rrun;
  end
  function automatic logic in_rng(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rdv, exp);
  endtask
  task automatic pulse(int n);
    width <= n[15:0];
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  task automatic idle;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 20000 && (integrate_reg || readout_reg); i++) @(posedge pclk);
    check("idle reached", integrate_reg || readout_reg, 32'h0);
    @(posedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(33182));
    e = 40 + $urandom % 20;
    r = 20 + $urandom % 10;
    w = 5 + $urandom % 20;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CET_OFF_CTRL, 32'h0, "ctrl");
    rd(CET_OFF_EXPOSURE, CET_EXPOSURE_RESET, "exposure");
    rd(CET_OFF_READOUT, CET_READOUT_RESET, "readout");
    rd(CET_OFF_PERIOD, CET_PERIOD_RESET, "period");
    rd(8'h1C, 32'h0, "unmapped");
    check("slverr", err, 32'h1);
    check("power lamp on", lamp_power_reg, 32'h1);
    power_switch_on <= 1'b0;
    repeat (2) @(posedge pclk);
    check("power lamp off", lamp_power_reg, 32'h0);
    power_switch_on <= 1'b1;
    apb(1'b1, CET_OFF_CTRL, 32'h10);
    @(posedge pclk);
    check("cool lamp on", lamp_cooling_reg, 32'h1);
    apb(1'b1, CET_OFF_CTRL, 32'h00);
    @(posedge pclk);
    check("cool lamp off", lamp_cooling_reg, 32'h0);
    apb(1'b1, CET_OFF_EXPOSURE, e);
    apb(1'b1, CET_OFF_READOUT, r);
    apb(1'b1, CET_OFF_CTRL, 32'h29);
    pulse(3);
    repeat (8) @(posedge pclk);
    check("trigger mask", secondary_sync_out_reg, 32'h1);
    pulse(3);
    for (int i = 0; i < 5000 && !readout_reg; i++) @(posedge pclk);
    check("readout seen", readout_reg, 32'h1);
    pulse(3);
    idle();
    check("mask while idle", secondary_sync_out_reg, 32'h0);
    check("exposure length", in_rng(ilen, e - 1, e + 1), 32'h1);
    check("readout length", in_rng(rlen, r - 1, r + 1), 32'h1);
    rd(CET_OFF_COUNT, 32'h2, "count overlap");
    apb(1'b1, CET_OFF_CTRL, 32'h22);
    pulse(3);
    idle();
    rd(CET_OFF_COUNT, 32'h3, "count falling edge");
    apb(1'b1, CET_OFF_CTRL, 32'h25);
    apb(1'b1, CET_OFF_COMMAND, 32'h1);
    idle();
    check("soft length", in_rng(ilen, e - 1, e + 1), 32'h1);
    rd(CET_OFF_COUNT, 32'h4, "count soft");
    apb(1'b1, CET_OFF_CTRL, 32'h00);
    act <= 1'b1;
    apb(1'b1, CET_OFF_CTRL, 32'h23);
    pulse(w);
    idle();
    check("high pulse length", ilen, w);
    apb(1'b1, CET_OFF_CTRL, 32'h00);
    act <= 1'b0;
    apb(1'b1, CET_OFF_CTRL, 32'h24);
    pulse(w);
    idle();
    check("low pulse length", ilen, w);
    apb(1'b1, CET_OFF_PERIOD, 32'h12C);
    apb(1'b1, CET_OFF_CTRL, 32'h20);
    pulse(3);
    repeat (1000) @(posedge pclk);
    apb(1'b1, CET_OFF_CTRL, 32'h00);
    idle();
    apb(1'b0, CET_OFF_COUNT, 32'h0);
    check("continual starts", in_rng(rdv, 9, 11), 32'h1);
    close_out();
  end
endmodule
bind cet_exposure_trigger cet_exposure_trigger_props #(.COOLED(COOLED)) u_props (.*);
